// [dv/flash_erase_id_security_cmds_tb.sv]
// self-checking bench for the flash command block
`default_nettype none
module flash_erase_id_security_cmds_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import flash_cmd_pkg::*;

    localparam logic [7:0]   MAKER  = 8'hC3;  // arbitrary
    localparam logic [7:0]   DEVID  = 8'h4E;  // arbitrary
    localparam logic [7:0]   MTYPE  = 8'h61;  // arbitrary
    localparam logic [7:0]   CAPAC  = 8'h19;  // arbitrary
    localparam logic [127:0] UID    = 128'hFEDCBA98765432100F1E2D3C4B5A6978; // arbitrary

    logic         clk_i;
    logic         rst_i;
    logic         sclk;
    logic         cs_n;
    logic         si;
    logic         so;
    logic         so_oe;
    logic         quad_mode;
    logic [2:0]   bp;
    logic         cmp;
    logic [2:0]   lock;
    logic         busy;
    logic         write_enable_latch;
    logic [3:0]   dummy;
    logic [6:0]   wrap;
    logic [127:0] rd;
    logic         oe;
    int           n_mismatch;
    int           checks_done;
    logic [7:0]   ce_ops [2] = '{OP_CHIP_ERASE_A, OP_CHIP_ERASE_B};
    logic [3:0]   dum [4] = '{4'h4, 4'h4, 4'h6, 4'h8};

    flash_cmd_seq #(
        .SEC_ERASE_CYC (1100),
        .SEC_PROG_CYC  (300),
        .CHIP_ERASE_CYC(2000),
        .MAKER_CODE    (MAKER),
        .DEVICE_CODE   (DEVID),
        .MEM_TYPE      (MTYPE),
        .CAPACITY      (CAPAC),
        .UNIQUE_ID     (UID)
    ) flash_cmd_seq_inst (
        .clk_i                   (clk_i),
        .rst_i                   (rst_i),
        .sclk_i                  (sclk),
        .cs_n_i                  (cs_n),
        .si_i                    (si),
        .so_o                    (so),
        .so_oe_o                 (so_oe),
        .quad_command_mode_i     (quad_mode),
        .block_protect_bits_i    (bp),
        .protect_complement_bit_i(cmp),
        .security_lock_bits_i    (lock),
        .busy_flag_o             (busy),
        .write_enable_latch_o    (write_enable_latch),
        .read_dummy_clocks_o     (dummy),
        .wrap_length_o           (wrap)
    );

    spi_host_model spi_host_model_inst (
        .sclk_o  (sclk),
        .cs_n_o  (cs_n),
        .si_o    (si),
        .so_i    (so),
        .so_oe_i (so_oe)
    );

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic give_verdict;
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask : check

    // write-type frame, then let the status settle
    task automatic cmd(input int n, input logic [63:0] din);
        logic [127:0] d;
        logic         o;
        spi_host_model_inst.frame(n, din, 0, d, o);
        @(negedge clk_i);
    endtask : cmd

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 5000) begin
            @(negedge clk_i);
            n++;
        end
        if (n >= 5000) begin
            n_mismatch++;
            give_verdict();
        end
    endtask : wait_idle

    initial begin
        rst_i = 1'b1;
        quad_mode = 1'b0;
        bp = 3'h0;
        cmp = 1'b0;
        lock = 3'h2; // only register two locked
        n_mismatch = 0;
        checks_done = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        spi_host_model_inst.frame(8, 64'h9F, 12, rd, oe);
        check(rd, {116'h0, MAKER, MTYPE[7:4]}, "short id read");
        spi_host_model_inst.frame(8, 64'h9F, 24, rd, oe);
        check(rd, {104'h0, MAKER, MTYPE, CAPAC}, "standard id read");
        spi_host_model_inst.frame(32, 64'h90000000, 16, rd, oe);
        check(rd, {112'h0, MAKER, DEVID}, "maker device id");
        spi_host_model_inst.frame(40, {24'h0, OP_UNIQUE_ID, 32'h0}, 128, rd, oe);
        check(rd, UID, "unique id");
        cmd(8, {56'h0, OP_CHIP_ERASE_A});
        check(busy, 1'b0, "erase without latch");
        cmd(8, {56'h0, OP_WRITE_UNLOCK});
        check(write_enable_latch, 1'b1, "latch set");
        @(posedge clk_i);
        bp <= 3'h1;
        cmd(8, {56'h0, OP_CHIP_ERASE_A});
        check({busy, write_enable_latch}, 2'b01, "erase while protected");
        @(posedge clk_i);
        bp <= 3'h7;
        cmp <= 1'b1;
        cmd(9, {55'h0, OP_CHIP_ERASE_B, 1'b0});
        check({busy, write_enable_latch}, 2'b01, "erase with extra bit");
        foreach (ce_ops[k]) begin
            cmd(8, {56'h0, OP_WRITE_UNLOCK});
            cmd(8, {56'h0, ce_ops[k]});
            check({busy, write_enable_latch}, 2'b10, "chip erase start");
            spi_host_model_inst.frame(8, {56'h0, OP_STD_ID}, 8, rd, oe);
            check({oe, busy}, 2'b01, "id read while busy");
            wait_idle();
        end
        @(posedge clk_i);
        bp <= 3'h0;
        cmp <= 1'b0;
        cmd(8, {56'h0, OP_WRITE_UNLOCK});
        cmd(32, {32'h0, OP_SEC_ERASE, 24'h001000});
        check({busy, write_enable_latch}, 2'b10, "security erase start");
        wait_idle();
        cmd(8, {56'h0, OP_WRITE_UNLOCK});
        cmd(56, {8'h0, OP_SEC_PROG, 24'h0013FE, 24'hA55A3C});
        check({busy, write_enable_latch}, 2'b10, "security program start");
        wait_idle();
        spi_host_model_inst.frame(40, {24'h0, OP_SEC_READ, 24'h0013FE, 8'h00}, 24, rd, oe);
        check(rd, {104'h0, 24'hA55AFF}, "security read wrap");
        spi_host_model_inst.frame(40, {24'h0, OP_SEC_READ, 24'h0012FF, 8'h00}, 16, rd, oe);
        check(rd, {112'h0, 16'hFF3C}, "program wraps in page");
        cmd(8, {56'h0, OP_WRITE_UNLOCK});
        cmd(48, {16'h0, OP_SEC_PROG, 24'h0023FE, 16'h1234});
        check({busy, write_enable_latch}, 2'b01, "locked program");
        cmd(32, {32'h0, OP_SEC_ERASE, 24'h002000});
        check({busy, write_enable_latch}, 2'b01, "locked erase");
        cmd(32, {32'h0, OP_SEC_ERASE, 24'h004000});
        check({busy, write_enable_latch}, 2'b01, "bad security address");
        @(posedge clk_i);
        quad_mode <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            cmd(16, {48'h0, OP_READ_PARAM, 2'b00, f[1:0], 2'b00, f[1:0]});
            check({dummy, wrap}, {dum[f], 7'h08 << f}, "read parameters");
        end
        @(posedge clk_i);
        quad_mode <= 1'b0;
        cmd(16, {48'h0, OP_SET_WRAP, 1'b0, 2'b10, 5'h00});
        check({dummy, wrap}, {DUMMY_FIXED, 7'h20}, "single lane setting");
        @(posedge clk_i);
        quad_mode <= 1'b1;
        @(negedge clk_i);
        check(wrap, 7'h20, "wrap kept in quad");
        give_verdict();
    end
endmodule : flash_erase_id_security_cmds_tb
`default_nettype wire

// [dv/spi_host_model.sv]
// host side of the serial link: frames commands and collects read data
`default_nettype none
module spi_host_model (
    // serial link
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      si_o,
    input  wire logic so_i,
    input  wire logic so_oe_i
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // clock stands still between frames; never sends power-down, so no id read lands there
    task automatic frame(input int n_in, input logic [63:0] din, input int n_out,
                         output logic [127:0] dout, output logic oe_seen);
        dout    = '0;
        oe_seen = 1'b0;
        cs_n_o  = 1'b0; // select held low for the whole frame
        for (int i = 0; i < n_in + n_out; i++) begin
            // msb first, opcode then address
            si_o = (i < n_in) ? din[n_in-1-i] : 1'b0;
            #24;
            sclk_o = 1'b1;
            if (i >= n_in) begin
                // released line reads inverted so a stale bit never passes
                dout    = {dout[126:0], so_oe_i ? so_i : ~so_i};
                oe_seen = oe_seen | so_oe_i;
            end
            #24;
            sclk_o = 1'b0;
        end
        #24;
        cs_n_o = 1'b1; // may cut output short at any bit
        #200;
    endtask : frame
endmodule : spi_host_model
`default_nettype wire

// [src/flash_cmd_pkg.sv]
// opcodes, frame lengths, field layouts and sequencer states for the command block
`default_nettype none
package flash_cmd_pkg;
    localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
    localparam logic [7:0] OP_READ_PARAM   = 8'hC0;
    localparam logic [7:0] OP_SET_WRAP     = 8'h77;
    localparam logic [7:0] OP_MAKER_ID     = 8'h90;
    localparam logic [7:0] OP_STD_ID       = 8'h9F;
    localparam logic [7:0] OP_UNIQUE_ID    = 8'h4B;
    localparam logic [7:0] OP_SEC_ERASE    = 8'h44;
    localparam logic [7:0] OP_SEC_PROG     = 8'h42;
    localparam logic [7:0] OP_SEC_READ     = 8'h48;

    localparam int CNT_W = 20;
    localparam logic [CNT_W-1:0] BITS_OPCODE   = 20'h00008;
    localparam logic [CNT_W-1:0] BITS_PARAM    = 20'h00010;
    localparam logic [CNT_W-1:0] BITS_ADDR     = 20'h00020;
    localparam logic [CNT_W-1:0] BITS_PROG_MIN = 20'h00028;
    localparam logic [CNT_W-1:0] LAST_OP_BIT   = 20'h00007;
    localparam logic [CNT_W-1:0] LAST_ADDR_BIT = 20'h0001F;
    localparam logic [CNT_W-1:0] LAST_DATA0    = 20'h00027;

    // header bytes before the first output byte
    localparam logic [CNT_W-4:0] HDR_STD_ID   = 17'h00001;
    localparam logic [CNT_W-4:0] HDR_MAKER_ID = 17'h00004;
    localparam logic [CNT_W-4:0] HDR_UNIQUE   = 17'h00005;
    localparam logic [CNT_W-4:0] HDR_SEC_READ = 17'h00005;

    localparam logic [7:0] SEC_ADDR_HI  = 8'h00;
    localparam logic [1:0] SEC_ADDR_GAP = 2'h0;
    localparam logic [3:0] SEC_SEL_MIN  = 4'h1;
    localparam logic [3:0] SEC_SEL_MAX  = 4'h3;
    localparam int         SEC_BYTES    = 1024;
    localparam int         PAGE_BYTES   = 256;
    localparam logic [7:0] ERASED_BYTE  = 8'hFF;

    localparam int DUMMY_LSB   = 4;
    localparam int WRAP_LSB    = 0;
    localparam int WRAPSEL_LSB = 5;
    localparam logic [3:0] DUMMY_FIXED = 4'h8;

    typedef enum logic [1:0] {
        ST_IDLE       = 2'b00,
        ST_SEC_ERASE  = 2'b01,
        ST_SEC_PROG   = 2'b11,
        ST_CHIP_ERASE = 2'b10
    } seq_state_t;

    function automatic logic [3:0] dummy_clocks(input logic [1:0] f);
        case (f)
            2'h2:    dummy_clocks = 4'h6;
            2'h3:    dummy_clocks = 4'h8;
            default: dummy_clocks = 4'h4;
        endcase
    endfunction : dummy_clocks

    function automatic logic [6:0] wrap_bytes(input logic [1:0] f);
        case (f)
            2'h0:    wrap_bytes = 7'h08;
            2'h1:    wrap_bytes = 7'h10;
            2'h2:    wrap_bytes = 7'h20;
            default: wrap_bytes = 7'h40;
        endcase
    endfunction : wrap_bytes
endpackage : flash_cmd_pkg
`default_nettype wire

// [src/flash_cmd_seq.sv]
// serial flash command decoder, id reads, security registers and erase sequencer
//
// What this block does
// - chip erase, opcode 60h or C7h, no address, needs write enable latch set.
// - chip erase runs only if select rises right after the eighth bit.
// - accepted chip erase raises busy until done and clears the write enable latch.
// - chip erase runs only when no sector is protected.
// - in quad mode the parameter command sets dummy clocks and wrap length.
// - dummy field 00/01 gives 4 clocks, 10 gives 6, 11 gives 8.
// - wrap field selects 8, 16, 32 or 64 byte boundary.
// - wrap setting from the single-lane wrap command survives entering quad mode.
// - maker/device id read: opcode, zero address, then maker and device code.
// - standard id read returns maker, memory type and capacity bytes, MSB first.
// - standard id read is not decoded while a cycle runs and disturbs nothing.
// - raising select ends the id read; device then waits for a new frame.
// - unique id read: opcode, three zero bytes, dummy byte, 128-bit value.
// - three 1024-byte security registers, erased and programmed independently.
// - security erase needs latch set, select rising right after the address.
// - security address: top byte zero, register 1..3 in 15-12, 11-10 zero.
// - security erase raises busy for the cycle and clears the latch.
// - a set lock bit makes erase and program of that register ignored.
// - security program needs latch set, address and data; four pages per register.
// - security program raises busy for a page program time, clears the latch.
// - security read takes opcode, address, dummy byte, then shifts data out.
// - security read offset increments and wraps from last byte to zero.
// - over 256 data bytes keeps the last 256 within the page.
`default_nettype none
module flash_cmd_seq
    import flash_cmd_pkg::*;
#(
    parameter int                 SEC_ERASE_CYC = 40000,
    parameter int                 SEC_PROG_CYC  = 12000,
    parameter int                 CHIP_ERASE_CYC = 400000,
    parameter logic [7:0]         MAKER_CODE    = 8'hA5, // arbitrary
    parameter logic [7:0]         DEVICE_CODE   = 8'h5A, // arbitrary
    parameter logic [7:0]         MEM_TYPE      = 8'h3C, // arbitrary
    parameter logic [7:0]         CAPACITY      = 8'h17, // arbitrary
    parameter logic [127:0]       UNIQUE_ID     =
        128'h0123456789ABCDEF0011223344556677 // arbitrary
) (
    // system
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // serial link
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       si_i,
    output logic            so_o,
    output logic            so_oe_o,
    // configuration from the rest of the device
    input  wire logic       quad_command_mode_i,
    input  wire logic [2:0] block_protect_bits_i,
    input  wire logic       protect_complement_bit_i,
    input  wire logic [2:0] security_lock_bits_i,
    // status
    output logic            busy_flag_o,
    output logic            write_enable_latch_o,
    output logic [3:0]      read_dummy_clocks_o,
    output logic [6:0]      wrap_length_o
);
    localparam int TMR_W = 32;

    // ---------------- link domain (sclk) ----------------
    logic [CNT_W-1:0] bit_cnt_r;
    logic [CNT_W-1:0] frame_len_r;
    logic [31:0]      sr_r;
    logic [7:0]       opcode_r;
    logic [23:0]      addr_r;
    logic [7:0]       pg_ptr_r;
    logic [PAGE_BYTES-1:0] pg_mask_r;
    logic [7:0]       pg_buf [PAGE_BYTES];
    logic             busy_l1_r;
    logic             busy_l2_r;
    logic             so_r;
    logic             oe_r;
    logic             busy_r;

    wire [7:0]       byte_in   = {sr_r[6:0], si_i};
    wire             byte_done = (bit_cnt_r[2:0] == 3'h7);
    // a program frame sent while busy must not touch the page being copied
    wire             data_byte = byte_done && (bit_cnt_r >= LAST_DATA0)
                                 && (opcode_r == OP_SEC_PROG) && !busy_l2_r;
    wire             pg_load   = (bit_cnt_r == LAST_ADDR_BIT) && (opcode_r == OP_SEC_PROG)
                                 && !busy_l2_r;
    wire [CNT_W-4:0] byte_num  = bit_cnt_r[CNT_W-1:3];

    // select high clears the bit count, so every frame starts at its opcode
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            bit_cnt_r <= '0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 1'b1;
        end
    end

    // captured frame stays put after select rises; the system side reads it then
    always_ff @(posedge sclk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_len_r <= '0;
            sr_r        <= '0;
            opcode_r    <= '0;
            addr_r      <= '0;
            pg_ptr_r    <= '0;
            pg_mask_r   <= '0;
            busy_l1_r   <= 1'b0;
            busy_l2_r   <= 1'b0;
        end else begin
            busy_l1_r   <= busy_r;
            busy_l2_r   <= busy_l1_r;
            frame_len_r <= bit_cnt_r + 1'b1;
            sr_r        <= {sr_r[30:0], si_i};
            if (bit_cnt_r == LAST_OP_BIT) begin
                opcode_r <= byte_in;
            end
            if (bit_cnt_r == LAST_ADDR_BIT) begin
                addr_r    <= {sr_r[22:0], si_i};
            end
            if (pg_load) begin
                pg_ptr_r  <= {sr_r[6:0], si_i};
                pg_mask_r <= '0;
            end else if (data_byte) begin
                pg_mask_r[pg_ptr_r] <= 1'b1;
                pg_ptr_r            <= pg_ptr_r + 1'b1; // wraps inside the page
            end
        end
    end

    // later bytes overwrite earlier ones at the same offset
    always_ff @(posedge sclk_i) begin
        if (data_byte) begin
            pg_buf[pg_ptr_r] <= byte_in;
        end
    end

    // ---------------- security register storage ----------------
    logic [7:0] sec_mem [3*SEC_BYTES];
    logic       mem_we;
    logic [11:0] mem_wa;
    logic [7:0] mem_wd;

    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            sec_mem[mem_wa] <= mem_wd;
        end
    end

    // ---------------- output path ----------------
    wire [3:0]  sec_sel  = addr_r[15:12];
    wire        sec_ok   = (addr_r[23:16] == SEC_ADDR_HI) && (addr_r[11:10] == SEC_ADDR_GAP)
                           && (sec_sel >= SEC_SEL_MIN) && (sec_sel <= SEC_SEL_MAX);
    wire [1:0]  sec_idx  = 2'(sec_sel - SEC_SEL_MIN);
    // offset rolls from the last byte back to zero
    wire [9:0]  rd_off   = addr_r[9:0] + 10'(byte_num - HDR_SEC_READ);
    // reads the array across domains; it only changes while busy, and reads are
    // blocked while busy, so the word is stable when sampled
    wire [7:0]  sec_rd   = sec_mem[{sec_idx, rd_off}];
    wire [CNT_W-4:0] id_num = byte_num - HDR_STD_ID;
    wire [CNT_W-4:0] mk_num = byte_num - HDR_MAKER_ID;
    wire [CNT_W-4:0] uq_num = byte_num - HDR_UNIQUE;
    wire [6:0]  uq_lsb   = {uq_num[3:0], 3'h0};
    wire [7:0]  uq_byte  = 8'(UNIQUE_ID >> (7'h78 - uq_lsb));

    logic [7:0] tx_byte;
    logic       tx_en;
    always_comb begin
        tx_byte = 8'h00;
        tx_en   = 1'b0;
        case (opcode_r)
            OP_STD_ID: begin
                tx_en   = (byte_num >= HDR_STD_ID) && !busy_l2_r;
                tx_byte = (id_num == 17'h0) ? MAKER_CODE :
                          (id_num == 17'h1) ? MEM_TYPE :
                          (id_num == 17'h2) ? CAPACITY : 8'h00;
            end
            OP_MAKER_ID: begin
                tx_en   = (byte_num >= HDR_MAKER_ID) && (addr_r == 24'h000000);
                tx_byte = mk_num[0] ? DEVICE_CODE : MAKER_CODE;
            end
            OP_UNIQUE_ID: begin
                tx_en   = (byte_num >= HDR_UNIQUE) && !busy_l2_r;
                tx_byte = uq_byte;
            end
            OP_SEC_READ: begin
                tx_en   = (byte_num >= HDR_SEC_READ) && sec_ok && !busy_l2_r;
                tx_byte = sec_rd;
            end
            default: begin
                tx_en   = 1'b0;
                tx_byte = 8'h00;
            end
        endcase
    end

    // shifted out MSB first on the falling edge; select high floats the pin
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            so_r <= 1'b0;
            oe_r <= 1'b0;
        end else begin
            so_r <= tx_byte[~bit_cnt_r[2:0]];
            oe_r <= tx_en;
        end
    end
    assign so_o    = so_r;
    assign so_oe_o = oe_r;

    // ---------------- system domain (clk) ----------------
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_s3_r;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_s3_r <= 1'b1;
        end else begin
            cs_s1_r <= cs_n_i;
            cs_s2_r <= cs_s1_r;
            cs_s3_r <= cs_s2_r;
        end
    end
    wire frame_end = cs_s2_r && !cs_s3_r;

    seq_state_t  state_r;
    seq_state_t  state_nxt;
    logic [TMR_W-1:0] timer_r;
    logic [10:0] idx_r;
    logic [1:0]  tgt_sec_r;
    logic [1:0]  tgt_page_r;
    logic        wel_r;
    logic [1:0]  dummy_field_r;
    logic [1:0]  wrap_field_r;

    wire is_chip   = (opcode_r == OP_CHIP_ERASE_A) || (opcode_r == OP_CHIP_ERASE_B);
    wire len_op    = (frame_len_r == BITS_OPCODE);
    wire len_addr  = (frame_len_r == BITS_ADDR);
    wire len_parm  = (frame_len_r == BITS_PARAM);
    wire len_prog  = (frame_len_r >= BITS_PROG_MIN) && (frame_len_r[2:0] == 3'h0);
    wire prot_none = ((block_protect_bits_i == 3'h0) && !protect_complement_bit_i)
                     || ((block_protect_bits_i == 3'h7) && protect_complement_bit_i);
    wire sec_lock  = security_lock_bits_i[sec_idx];
    wire cmd_ok    = frame_end && !busy_r;

    wire start_chip = cmd_ok && is_chip && len_op && wel_r && prot_none;
    wire start_serase = cmd_ok && (opcode_r == OP_SEC_ERASE) && len_addr && wel_r
                        && sec_ok && !sec_lock;
    wire start_sprog  = cmd_ok && (opcode_r == OP_SEC_PROG) && len_prog && wel_r
                        && sec_ok && !sec_lock;
    wire do_unlock = cmd_ok && (opcode_r == OP_WRITE_UNLOCK) && len_op;
    wire set_param = cmd_ok && (opcode_r == OP_READ_PARAM) && len_parm && quad_command_mode_i;
    wire set_wrap  = cmd_ok && (opcode_r == OP_SET_WRAP) && len_parm && !quad_command_mode_i;
    wire any_start = start_chip || start_serase || start_sprog;
    wire [1:0] param_dummy = sr_r[DUMMY_LSB+1:DUMMY_LSB];
    wire last_tick = (timer_r == TMR_W'(1));

    assign busy_r = (state_r != ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (start_chip) begin
                    state_nxt = ST_CHIP_ERASE;
                end else if (start_serase) begin
                    state_nxt = ST_SEC_ERASE;
                end else if (start_sprog) begin
                    state_nxt = ST_SEC_PROG;
                end
            end
            default: begin
                if (last_tick) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r    <= ST_IDLE;
            timer_r    <= '0;
            idx_r      <= '0;
            tgt_sec_r  <= '0;
            tgt_page_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (any_start) begin
                timer_r    <= start_chip ? TMR_W'(CHIP_ERASE_CYC) :
                              start_serase ? TMR_W'(SEC_ERASE_CYC) : TMR_W'(SEC_PROG_CYC);
                idx_r      <= '0;
                tgt_sec_r  <= sec_idx;
                tgt_page_r <= addr_r[9:8];
            end else if (busy_r) begin
                timer_r <= timer_r - 1'b1;
                idx_r   <= (idx_r[10]) ? idx_r : idx_r + 1'b1;
            end
        end
    end

    // erase walks the whole register; program copies only bytes that arrived
    assign mem_we = ((state_r == ST_SEC_ERASE) && !idx_r[10])
                    || ((state_r == ST_SEC_PROG) && (idx_r < 11'(PAGE_BYTES))
                        && pg_mask_r[idx_r[7:0]]);
    assign mem_wa = (state_r == ST_SEC_ERASE) ? {tgt_sec_r, idx_r[9:0]} :
                    {tgt_sec_r, tgt_page_r, idx_r[7:0]};
    assign mem_wd = (state_r == ST_SEC_ERASE) ? ERASED_BYTE : pg_buf[idx_r[7:0]];

    // latch drops as a cycle starts, well before it ends
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wel_r <= 1'b0;
        end else if (do_unlock) begin
            wel_r <= 1'b1;
        end else if (any_start) begin
            wel_r <= 1'b0;
        end
    end

    // wrap field is not touched by a mode change, only by its two commands
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            dummy_field_r <= '0;
            wrap_field_r  <= '0;
        end else if (set_param) begin
            dummy_field_r <= sr_r[DUMMY_LSB+1:DUMMY_LSB];
            wrap_field_r  <= sr_r[WRAP_LSB+1:WRAP_LSB];
        end else if (set_wrap) begin
            wrap_field_r  <= sr_r[WRAPSEL_LSB+1:WRAPSEL_LSB];
        end
    end

    assign busy_flag_o          = busy_r;
    assign write_enable_latch_o = wel_r;
    assign read_dummy_clocks_o  = quad_command_mode_i ? dummy_clocks(dummy_field_r)
                                                      : DUMMY_FIXED;
    assign wrap_length_o        = wrap_bytes(wrap_field_r);

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chip_start_a: assert property (start_chip |=> busy_flag_o && !write_enable_latch_o)
        else $error("chip erase did not raise busy");
    prot_block_a: assert property (cmd_ok && is_chip && !prot_none |=> !busy_flag_o)
        else $error("chip erase ran while protected");
    need_latch_a: assert property ($rose(busy_flag_o) |-> $past(wel_r))
        else $error("cycle started without write enable latch");
    lock_ignore_a: assert property (cmd_ok && sec_ok && sec_lock && !is_chip
                                    |=> !busy_flag_o)
        else $error("locked security register was touched");
    busy_hold_a: assert property ($rose(busy_flag_o) |-> busy_flag_o [*8])
        else $error("busy dropped too early");
    dummy_map_a: assert property (quad_command_mode_i && dummy_field_r == 2'h2
                                  |-> read_dummy_clocks_o == 4'h6)
        else $error("dummy count mapping wrong");
    dummy_fixed_a: assert property (!quad_command_mode_i
                                    |-> read_dummy_clocks_o == DUMMY_FIXED)
        else $error("single lane dummy count changed");
    wrap_map_a: assert property (wrap_field_r == 2'h1 |-> wrap_length_o == 7'h10)
        else $error("wrap length mapping wrong");
    wrap_keep_a: assert property ($rose(quad_command_mode_i) |-> $stable(wrap_field_r))
        else $error("wrap setting lost on mode switch");
    param_set_a: assert property (set_param |=> dummy_field_r == $past(param_dummy))
        else $error("read parameters not taken");
endmodule : flash_cmd_seq
`default_nettype wire
